//--- hdl/disk_ctrl_defines.svh
// Function
// [R01] attention line is the or of all drive attention bits, units 0..7
// [R02] drive sets attention on error summary or finished head movement
// [R03] error summary is set while any drive error bit is set
// [R04] transferring drive reports errors on exception line, never attention
// [R05] end-of-block pulses each sector; exception sampled only during it
// [R06] controller clear wipes errors, silo, address, select, enable, port, bai, pat
// [R07] controller clear pulses drive init; drives clear errors, function, address
// [R08] transfer error write clears only controller error bits
// [R09] drive clear command clears errors, function, address of selected drive
// [R10] controller error clear and drive clear leave each other alone
// [R11] host-bus init acts as controller clear, all drives included
// [R12] transfer command with go clears controller errors and silo only
// [R13] transfer needs both readies; other commands need only drive ready
// [R14] transfer start drops both readies; other command drops drive ready; drive_unit keeps drive ready set on drive clear
// [R15] ready returns after drive ready, last memory cycle, run negated
// [R16] drive with error summary ignores all but drive clear
// [R17] transfer to erroring drive is not run and sets missed transfer
// [R18] interrupt when ready rises after transfer with enable set
// [R19] interrupt when special condition rises while ready and enabled
// [R20] interrupt when software writes enable while ready
// [R21] software avoids read-modify-write of enable bit
// [R22] special condition is transfer error or attention or parity error
// [R23] transfer error set by controller error or exception at end-of-block
// [R24] each interrupt request stays pending until acknowledged
`ifndef DISK_CTRL_DEFINES_SVH
`define DISK_CTRL_DEFINES_SVH
`define REG_CTRL 8'h00
`define REG_STAT2 8'h04
`define REG_BADDR 8'h08
`define REG_ATTENTION_LINE 8'h0c
`define REG_DSTAT 8'h10
`define REG_DADDR 8'h14
`define CS1_TRE 14
`define CS1_PSEL 10
`define CS1_AEXT_LO 8
`define CS1_IE 6
`define CS1_GO 0
`define CS2_CLR 5
`define CS2_PAT 4
`define CS2_BAI 3
`define MXF_IDX 1
`define FUNC_DCLR 5'h04
`define FUNC_XFER_MIN 5'h14
`endif

//--- hdl/disk_ctrl_pkg.sv
package disk_ctrl_pkg;
   typedef enum logic [1:0] {S_IDLE, S_RUN, S_DRAIN} xfer_state_t;
   typedef logic [4:0] func_t;
endpackage : disk_ctrl_pkg

//--- hdl/disk_ctrl_status_clear_irq.sv
`timescale 1ns/10ps
`include "disk_ctrl_defines.svh"
module disk_ctrl_status_clear_irq import disk_ctrl_pkg::*; #(
   parameter int NDRV = 8,
   parameter int EW = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic host_init_i,
   input wire logic irq_ack_i,
   input wire logic [7:0] ctrl_err_i,
   input wire logic control_parity_error_i,
   input wire logic wc_done_i,
   input wire logic dma_busy_i,
   input wire logic [NDRV*EW-1:0] err_src_i,
   input wire logic [NDRV-1:0] move_done_i,
   input wire logic [NDRV-1:0] sector_end_i,
   output logic irq_o,
   output logic attention_line_o,
   output logic run_o,
   output logic drive_init_o,
   output logic silo_clr_o
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   xfer_state_t state_q;
   xfer_state_t state_d;
   logic [NDRV*EW-1:0] err_s;
   logic [NDRV-1:0] move_s;
   logic [NDRV-1:0] sect_s;
   logic [NDRV-1:0] move_p_q;
   logic [NDRV-1:0] sect_p_q;
   logic [NDRV-1:0] ata_w;
   logic [NDRV-1:0] sum_w;
   logic [NDRV-1:0] dry_w;
   logic [NDRV-1:0] exc_w;
   logic [NDRV-1:0] eob_w;
   logic [15:0] da_w [NDRV];
   logic [7:0] cs2_err_q;
   logic exc_err_q;
   logic control_parity_error_q;
   logic psel_q;
   logic [1:0] aext_q;
   logic ie_q;
   func_t func_q;
   logic pat_q;
   logic bai_q;
   logic [2:0] unit_q;
   logic [2:0] xunit_q;
   logic [15:0] ba_q;
   logic done_pend_q;
   logic sc_prev_q;
   logic irq_q;
   logic ack_q;
   logic [31:0] rd_d;
   logic wr;
   logic wr_ctrl;
   logic wr_stat2;
   logic wr_ba;
   logic wr_attention_line;
   logic wr_da;
   logic ctl_clr;
   logic go;
   func_t fn;
   logic dclr_cmd;
   logic accept;
   logic xfer_start;
   logic mxf_set;
   logic err_clr;
   logic rdy;
   logic transfer_error_bit;
   logic sc;
   logic attention_line;
   logic sum_sel;
   logic dry_sel;
   logic eob_x;
   logic exc_x;
   logic dry_x;
   logic ie_wr1;
   logic rdy_rise;
   logic irq_set;

   function automatic logic is_xfer(input func_t f);
      return f >= `FUNC_XFER_MIN;
   endfunction : is_xfer

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   sync2 #(.W(NDRV*EW+2*NDRV)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i({err_src_i, move_done_i, sector_end_i}),
      .q_o({err_s, move_s, sect_s})
   );
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         move_p_q <= '0;
         sect_p_q <= '0;
      end
      else if (ce_i)
      begin
         move_p_q <= move_s;
         sect_p_q <= sect_s;
      end
   end

   // ----------------------------------------
   // drives
   // ----------------------------------------
   for (genvar i = 0; i < NDRV; i++)
   begin : g_drv
      drive_unit #(.EW(EW)) u_drv (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .ce_i(ce_i),
         .init_i(ctl_clr),
         .cmd_i(accept && unit_q == 3'(i)),
         .func_i(fn),
         .xfer_i(xfer_start && unit_q == 3'(i)),
         .stop_i(state_q == S_RUN && state_d != S_RUN && xunit_q == 3'(i)),
         .da_we_i(wr_da && unit_q == 3'(i)),
         .da_i(wb_dat_i[15:0]),
         .err_i(err_s[i*EW +: EW]),
         .move_done_i(move_s[i] && !move_p_q[i]),
         .sector_end_i(sect_s[i] && !sect_p_q[i]),
         .ata_clr_i(wr_attention_line && wb_sel_i[0] && wb_dat_i[i]),
         .err_sum_o(sum_w[i]),
         .ata_o(ata_w[i]),
         .dry_o(dry_w[i]),
         .exc_o(exc_w[i]),
         .eob_o(eob_w[i]),
         .da_o(da_w[i])
      );
   end

   // ----------------------------------------
   // decode
   // ----------------------------------------
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
   assign wr_ctrl = wr && wb_adr_i == `REG_CTRL;
   assign wr_stat2 = wr && wb_adr_i == `REG_STAT2;
   assign wr_ba = wr && wb_adr_i == `REG_BADDR && rdy;
   assign wr_attention_line = wr && wb_adr_i == `REG_ATTENTION_LINE;
   assign wr_da = wr && wb_adr_i == `REG_DADDR;
   assign ctl_clr = host_init_i || (wr_stat2 && wb_sel_i[0] && wb_dat_i[`CS2_CLR]); // [R06] [R11]
   assign fn = wb_dat_i[5:1];
   assign go = wr_ctrl && wb_sel_i[0] && wb_dat_i[`CS1_GO];
   assign dclr_cmd = fn == `FUNC_DCLR;
   assign sum_sel = sum_w[unit_q];
   assign dry_sel = dry_w[unit_q];
   assign rdy = state_q == S_IDLE;
   assign xfer_start = go && is_xfer(fn) && rdy && dry_sel && !sum_sel; // [R13]
   assign accept = go && dry_sel && !ctl_clr
      && (is_xfer(fn) ? xfer_start : (!sum_sel || dclr_cmd)); // [R13] [R16]
   assign mxf_set = go && is_xfer(fn) && rdy && dry_sel && sum_sel; // [R17]
   assign err_clr = ctl_clr || (wr_ctrl && wb_sel_i[1] && wb_dat_i[`CS1_TRE])
      || (go && is_xfer(fn)); // [R08] [R10] [R12]
   assign eob_x = eob_w[xunit_q];
   assign exc_x = exc_w[xunit_q];
   assign dry_x = dry_w[xunit_q];
   assign attention_line = |ata_w; // [R01]
   assign transfer_error_bit = (|cs2_err_q) || exc_err_q; // [R23]
   assign sc = transfer_error_bit || attention_line || control_parity_error_q; // [R22]

   // ----------------------------------------
   // controller errors
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cs2_err_q <= '0;
         exc_err_q <= 1'b0;
         control_parity_error_q <= 1'b0;
      end
      else if (ce_i)
      begin
         cs2_err_q <= (err_clr ? '0 : cs2_err_q) | ctrl_err_i
            | (8'(mxf_set) << `MXF_IDX); // [R17]
         exc_err_q <= (exc_err_q && !err_clr)
            || (state_q == S_RUN && eob_x && exc_x); // [R05] [R23]
         control_parity_error_q <= (control_parity_error_q && !err_clr) || control_parity_error_i;
      end
   end

   // ----------------------------------------
   // control fields
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i || (ce_i && ctl_clr))
      begin
         psel_q <= 1'b0; // [R06]
         aext_q <= '0;
         ie_q <= 1'b0;
         pat_q <= 1'b0;
         bai_q <= 1'b0;
         unit_q <= '0;
         ba_q <= '0;
         func_q <= '0;
      end
      else if (ce_i)
      begin
         if (wr_ctrl && wb_sel_i[0])
         begin
            ie_q <= wb_dat_i[`CS1_IE];
            func_q <= fn;
         end
         if (wr_ctrl && wb_sel_i[1] && rdy)
         begin
            psel_q <= wb_dat_i[`CS1_PSEL];
            aext_q <= wb_dat_i[`CS1_AEXT_LO +: 2];
         end
         if (wr_stat2 && wb_sel_i[0])
         begin
            pat_q <= wb_dat_i[`CS2_PAT];
            bai_q <= wb_dat_i[`CS2_BAI];
            unit_q <= wb_dat_i[2:0];
         end
         if (wr_ba)
            ba_q <= wb_dat_i[15:0];
      end
   end

   // ----------------------------------------
   // transfer sequencing
   // ----------------------------------------
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         S_IDLE:
            if (xfer_start)
               state_d = S_RUN; // [R14]
         S_RUN:
            if (eob_x && (done_pend_q || transfer_error_bit || exc_x))
               state_d = S_DRAIN;
         S_DRAIN:
            if (dry_x && !dma_busy_i)
               state_d = S_IDLE; // [R15]
      endcase
      if (ctl_clr)
         state_d = S_IDLE;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q <= S_IDLE;
         xunit_q <= '0;
         done_pend_q <= 1'b0;
      end
      else if (ce_i)
      begin
         state_q <= state_d;
         if (xfer_start)
            xunit_q <= unit_q;
         done_pend_q <= !xfer_start && !ctl_clr && (done_pend_q || wc_done_i);
      end
   end
   assign run_o = state_q == S_RUN;

   // ----------------------------------------
   // interrupt request
   // ----------------------------------------
   assign rdy_rise = state_q == S_DRAIN && state_d == S_IDLE && !ctl_clr;
   assign ie_wr1 = wr_ctrl && wb_sel_i[0] && wb_dat_i[`CS1_IE];
   assign irq_set = (rdy_rise && ie_q) // [R18]
      || (sc && !sc_prev_q && rdy && ie_q) // [R19]
      || (ie_wr1 && rdy); // [R20]
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_q <= 1'b0;
         sc_prev_q <= 1'b0;
      end
      else if (ce_i)
      begin
         irq_q <= (irq_q && !irq_ack_i) || irq_set; // [R24]
         sc_prev_q <= sc;
      end
   end
   assign irq_o = irq_q;

   // ----------------------------------------
   // status outputs
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         attention_line_o <= 1'b0;
         drive_init_o <= 1'b0;
         silo_clr_o <= 1'b0;
      end
      else if (ce_i)
      begin
         attention_line_o <= attention_line; // [R01]
         drive_init_o <= ctl_clr; // [R07]
         silo_clr_o <= ctl_clr || (go && is_xfer(fn)); // [R06] [R12]
      end
   end

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   always_comb
   begin
      rd_d = '0;
      unique case (wb_adr_i)
         `REG_CTRL:
            rd_d[15:0] = {sc, transfer_error_bit, control_parity_error_q, 2'b00, psel_q, aext_q,
               rdy, ie_q, func_q, 1'b0};
         `REG_STAT2:
            rd_d[15:0] = {cs2_err_q, 2'b00, 1'b0, pat_q, bai_q, unit_q};
         `REG_BADDR:
            rd_d[15:0] = ba_q;
         `REG_ATTENTION_LINE:
            rd_d[NDRV-1:0] = ata_w;
         `REG_DSTAT:
            rd_d[2*NDRV-1:0] = {dry_w, sum_w};
         `REG_DADDR:
            rd_d[15:0] = da_w[unit_q];
         default:
            rd_d = '0;
      endcase
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         wb_dat_o <= '0;
      end
      else if (ce_i)
      begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
         if (wb_cyc_i && wb_stb_i && !ack_q)
            wb_dat_o <= rd_d;
      end
   end
   assign wb_ack_o = ack_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_drain_exit;
      state_q == S_DRAIN ##1 state_q == S_IDLE;
   endsequence
   sequence s_clr_quiet;
      ce_i && ctl_clr && ctrl_err_i == '0 && !control_parity_error_i;
   endsequence

   a_attention_line_or_all: assert property (ce_i |=> attention_line_o == $past(|ata_w)) // [R01]
      else $error("attention not or of drives");
   a_clr_wipes: assert property (s_clr_quiet |=> !ie_q && unit_q == '0 // [R06]
      && ba_q == '0 && cs2_err_q == '0 && !transfer_error_bit && silo_clr_o)
      else $error("controller clear incomplete");
   a_init_pulse: assert property (ce_i && ctl_clr |=> drive_init_o && rdy) // [R07]
      else $error("drive init missing");
   a_errclr_only: assert property (ce_i && wr_ctrl && wb_sel_i[1] && wb_dat_i[`CS1_TRE] // [R08]
      && !ctl_clr && ctrl_err_i == '0 && !control_parity_error_i |=> cs2_err_q == '0 && $stable(unit_q))
      else $error("error clear wrong");
   a_xfer_gate: assert property (ce_i && go && is_xfer(fn) && !(rdy && dry_sel) // [R13]
      && state_q == S_IDLE |=> state_q == S_IDLE)
      else $error("transfer started without readies");
   a_start_drops: assert property (ce_i && xfer_start && !ctl_clr |=> !rdy && !dry_sel) // [R14]
      else $error("readies not dropped");
   a_rdy_cause: assert property (s_drain_exit |-> $past(ctl_clr) // [R15]
      || $past(dry_x && !dma_busy_i && ce_i))
      else $error("ready rose too early");
   a_mxf_sets: assert property (ce_i && mxf_set |=> cs2_err_q[`MXF_IDX] && transfer_error_bit && sc) // [R17]
      else $error("missed transfer not flagged");
   a_irq_ie: assert property (ce_i && ie_wr1 && rdy |=> irq_o) // [R20]
      else $error("enable write no interrupt");
   a_irq_hold: assert property (ce_i && irq_q && !irq_ack_i |=> irq_q) // [R24]
      else $error("interrupt request lost");
   a_tre_eob: assert property (ce_i && state_q == S_RUN && eob_x && exc_x // [R23]
      |=> transfer_error_bit && state_q != S_RUN) else $error("exception not taken");
endmodule : disk_ctrl_status_clear_irq

//--- hdl/drive_unit.sv
`timescale 1ns/10ps
`include "disk_ctrl_defines.svh"
module drive_unit import disk_ctrl_pkg::*; #(
   parameter int EW = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic init_i,
   input wire logic cmd_i,
   input wire func_t func_i,
   input wire logic xfer_i,
   input wire logic stop_i,
   input wire logic da_we_i,
   input wire logic [15:0] da_i,
   input wire logic [EW-1:0] err_i,
   input wire logic move_done_i,
   input wire logic sector_end_i,
   input wire logic ata_clr_i,
   output logic err_sum_o,
   output logic ata_o,
   output logic dry_o,
   output logic exc_o,
   output logic eob_o,
   output logic [15:0] da_o
);
   logic [EW-1:0] errs_q;
   func_t func_q;
   logic xfer_q;
   logic dclr;
   logic take;
   assign err_sum_o = |errs_q; // [R03]
   assign dclr = cmd_i && func_i == `FUNC_DCLR;
   assign take = cmd_i && !err_sum_o && !dclr; // [R16]
   // ----------------------------------------
   // error and command state
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         errs_q <= '0;
      else if (ce_i)
         errs_q <= ((init_i || dclr) ? '0 : errs_q) | err_i; // [R07] [R09]
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i || (ce_i && (init_i || dclr)))
      begin
         func_q <= '0; // [R09]
         da_o <= '0;
      end
      else if (ce_i)
      begin
         if (take)
            func_q <= func_i;
         if (da_we_i)
            da_o <= da_i;
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dry_o <= 1'b1;
         xfer_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (init_i)
            dry_o <= 1'b1;
         else if (take)
            dry_o <= 1'b0; // [R14]
         else if (stop_i || (move_done_i && !xfer_q))
            dry_o <= 1'b1;
         xfer_q <= !init_i && (xfer_i || (xfer_q && !stop_i));
      end
   end
   // ----------------------------------------
   // attention, exception, end of block
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ata_o <= 1'b0;
         exc_o <= 1'b0;
         eob_o <= 1'b0;
      end
      else if (ce_i)
      begin
         ata_o <= !init_i && ((ata_o && !ata_clr_i)
            || (!xfer_q && (err_sum_o || move_done_i))); // [R02] [R04]
         exc_o <= xfer_q && err_sum_o; // [R04]
         eob_o <= xfer_q && sector_end_i; // [R05]
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_sum_tracks: assert property (@(posedge clk_i) disable iff (rst_i) // [R03]
      ce_i && !init_i && !dclr && err_i != '0 |=> err_sum_o) else $error("error summary wrong");
   a_no_attention_line_xfer: assert property (@(posedge clk_i) disable iff (rst_i) // [R04]
      ce_i && xfer_q && !ata_o |=> !ata_o) else $error("attention during transfer");
   a_dclr_wipes: assert property (@(posedge clk_i) disable iff (rst_i) // [R09]
      ce_i && dclr |=> func_q == '0 && da_o == '0) else $error("drive clear missed");
endmodule : drive_unit

//--- hdl/sync2.sv
`timescale 1ns/10ps
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta_q <= '0;
         q_o <= '0;
      end
      else if (ce_i)
      begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : sync2

//--- sim/drive_side_model.sv
`timescale 1ns/10ps
module drive_side_model (
   input wire logic clk_i,
   input wire logic [7:0] fault_i,
   input wire logic [7:0] move_req_i,
   input wire logic [7:0] sector_req_i,
   output logic [63:0] err_src_o,
   output logic [7:0] move_done_o,
   output logic [7:0] sector_end_o
);
   logic [2:0] len_q [8] = '{default: 3'h0};
   // ----------------------------------------
   // error sources and head movement
   // ----------------------------------------
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         err_src_o[i*8+:8] = {7'h00, fault_i[i]};
         sector_end_o[i] = len_q[i] != 3'h0;
      end
   end
   assign move_done_o = move_req_i;
   // ----------------------------------------
   // end of sector pulse, four cycles
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (sector_req_i[i])
            len_q[i] <= 3'h4;
         else if (len_q[i] != 3'h0)
            len_q[i] <= len_q[i] - 3'h1;
      end
   end
endmodule : drive_side_model

//--- sim/test_disk_ctrl_status_clear_irq.sv
`timescale 1ns/10ps
module test_disk_ctrl_status_clear_irq;
   import disk_ctrl_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat;
   logic ack, host_init = 1'b0, irq_ack = 1'b0, wc_done = 1'b0, dma_busy = 1'b0, control_parity_error = 1'b0;
   logic irq, attention_line, run, dinit, silo;
   logic [7:0] fault = 8'h00, move_req = 8'h00, sector_req = 8'h00, cerr = 8'h00, mv, se;
   logic [63:0] esrc;
   int error_cnt = 0, total_checks = 0;
   initial forever #10 clk_i = ~clk_i;
   drive_side_model far (.clk_i(clk_i), .fault_i(fault), .move_req_i(move_req),
      .sector_req_i(sector_req), .err_src_o(esrc), .move_done_o(mv), .sector_end_o(se));
   disk_ctrl_status_clear_irq uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .host_init_i(host_init),
      .irq_ack_i(irq_ack), .ctrl_err_i(cerr), .control_parity_error_i(control_parity_error), .wc_done_i(wc_done),
      .dma_busy_i(dma_busy), .err_src_i(esrc), .move_done_i(mv), .sector_end_i(se),
      .irq_o(irq), .attention_line_o(attention_line), .run_o(run), .drive_init_o(dinit),
      .silo_clr_o(silo));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask : chk
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wait_clk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50)
         chk("bus ack", 32'h1, 32'h0);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, {16'h0000, d}, q);
   endtask : wr
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(nm, exp, q & m);
   endtask : rdchk
   task automatic take_irq;
      @(posedge clk_i);
      irq_ack <= 1'b1;
      @(posedge clk_i);
      irq_ack <= 1'b0;
      wait_clk(1);
      chk("irq after ack", 32'h0, {31'h0, irq});
   endtask : take_irq
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      rdchk("ctrl ready", 8'h00, 32'hffff, 32'h0080);
      rdchk("drive status", 8'h10, 32'hffff, 32'hff00);
      rdchk("unmapped", 8'h40, 32'hffffffff, 32'h0);
   endtask : t_reset
   task automatic t_xfer;
      wr(8'h00, 16'h0040);
      wait_clk(2);
      chk("irq on enable", 32'h1, {31'h0, irq});
      wait_clk(3);
      chk("irq pending", 32'h1, {31'h0, irq});
      take_irq();
      wr(8'h04, 16'h0000);
      wr(8'h00, 16'h0069);
      wait_clk(2);
      chk("run", 32'h1, {31'h0, run});
      chk("irq on go with enable", 32'h1, {31'h0, irq});
      take_irq();
      rdchk("ctrl busy", 8'h00, 32'h0080, 32'h0);
      rdchk("drive 0 busy", 8'h10, 32'h0100, 32'h0);
      @(posedge clk_i);
      dma_busy <= 1'b1;
      wc_done <= 1'b1;
      @(posedge clk_i);
      wc_done <= 1'b0;
      sector_req <= 8'h01;
      @(posedge clk_i);
      sector_req <= 8'h00;
      wait_clk(14);
      chk("run ended", 32'h0, {31'h0, run});
      chk("no irq while dma", 32'h0, {31'h0, irq});
      dma_busy <= 1'b0;
      wait_clk(4);
      chk("irq at ready", 32'h1, {31'h0, irq});
      rdchk("ctrl ready back", 8'h00, 32'h0080, 32'h0080);
      take_irq();
   endtask : t_xfer
   task automatic t_attention_line;
      fault <= 8'h04;
      wait_clk(6);
      chk("attention line", 32'h1, {31'h0, attention_line});
      chk("irq on special", 32'h1, {31'h0, irq});
      take_irq();
      rdchk("error summary", 8'h10, 32'h00ff, 32'h0004);
      rdchk("special cond", 8'h00, 32'h8000, 32'h8000);
   endtask : t_attention_line
   task automatic t_errs;
      wr(8'h04, 16'h0002);
      wr(8'h00, 16'h0029);
      rdchk("missed xfer", 8'h04, 32'h0200, 32'h0200);
      rdchk("xfer error", 8'h00, 32'h4000, 32'h4000);
      rdchk("drive 2 ignored", 8'h10, 32'h0400, 32'h0400);
      wr(8'h00, 16'h4000);
      rdchk("ctrl errors", 8'h04, 32'hff00, 32'h0000);
      rdchk("summary kept", 8'h10, 32'h00ff, 32'h0004);
      @(posedge clk_i);
      cerr <= 8'h40;
      control_parity_error <= 1'b1;
      @(posedge clk_i);
      cerr <= 8'h00;
      control_parity_error <= 1'b0;
      rdchk("parity error", 8'h00, 32'h6000, 32'h6000);
      fault <= 8'h00;
      wr(8'h00, 16'h0009);
      rdchk("drive clear", 8'h10, 32'h00ff, 32'h0000);
      rdchk("tre kept", 8'h00, 32'h4000, 32'h4000);
      wr(8'h00, 16'h4000);
      rdchk("errors cleared", 8'h00, 32'h6000, 32'h0000);
      rdchk("status2 cleared", 8'h04, 32'hff00, 32'h0000);
   endtask : t_errs
   task automatic t_seek;
      wr(8'h04, 16'h0001);
      wr(8'h00, 16'h0005);
      rdchk("drive 1 busy", 8'h10, 32'h0200, 32'h0);
      rdchk("ctrl still ready", 8'h00, 32'h0080, 32'h0080);
      move_req <= 8'h02;
      wait_clk(6);
      rdchk("drive 1 ready", 8'h10, 32'h0200, 32'h0200);
      rdchk("seek attention", 8'h0c, 32'h0002, 32'h0002);
      move_req <= 8'h00;
   endtask : t_seek
   task automatic t_exc;
      wr(8'h04, 16'h0003);
      wr(8'h00, 16'h0029);
      fault <= 8'h08;
      wait_clk(6);
      rdchk("no attention in xfer", 8'h0c, 32'h0008, 32'h0000);
      rdchk("tre before eob", 8'h00, 32'h4080, 32'h0000);
      @(posedge clk_i);
      sector_req <= 8'h08;
      @(posedge clk_i);
      sector_req <= 8'h00;
      wait_clk(12);
      rdchk("tre after eob", 8'h00, 32'h4080, 32'h4080);
      rdchk("attention after xfer", 8'h0c, 32'h0008, 32'h0008);
   endtask : t_exc
   task automatic t_clear(input int m);
      logic seen_init, seen_silo;
      fault <= 8'h20;
      wr(8'h04, 16'h0005);
      fault <= 8'h00;
      wait_clk(4);
      if (m == 0)
         wr(8'h04, 16'h0020);
      else
      begin
         host_init <= 1'b1;
         @(posedge clk_i);
         host_init <= 1'b0;
      end
      seen_init = 1'b0;
      seen_silo = 1'b0;
      repeat (5)
      begin
         @(posedge clk_i);
         seen_init |= dinit;
         seen_silo |= silo;
      end
      chk("drive init", 32'h1, {31'h0, seen_init});
      chk("silo clear", 32'h1, {31'h0, seen_silo});
      rdchk("drives cleared", 8'h10, 32'h00ff, 32'h0);
      rdchk("unit select", 8'h04, 32'h0007, 32'h0);
   endtask : t_clear
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      wait_clk(16);
      rst_i <= 1'b0;
      t_reset();
      t_xfer();
      t_attention_line();
      t_errs();
      t_seek();
      t_exc();
      t_clear(0);
      t_clear(1);
      final_report();
   end
   initial
   begin
      wait_clk(20000);
      error_cnt++;
      final_report();
   end
endmodule : test_disk_ctrl_status_clear_irq
